// [common/hsq_consts.svh]
// constants for the homing sequencer
`ifndef HSQ_CONSTS_SVH
`define HSQ_CONSTS_SVH
`define HSQ_METHOD_10   8'h0A
`define HSQ_METHOD_11   8'h0B
`define HSQ_METHOD_12   8'h0C
`define HSQ_METHOD_13   8'h0D
`define HSQ_METHOD_14   8'h0E
`define HSQ_METHOD_15   8'h0F
`define HSQ_METHOD_16   8'h10
`define HSQ_METHOD_17   8'h11
`define HSQ_SPEED_FIRST 1'b0
`define HSQ_SPEED_SECOND 1'b1
`define HSQ_DIR_POS     1'b1
`define HSQ_DIR_NEG     1'b0
`endif

// [common/hsq_pkg.sv]
// types for the homing sequencer
package hsq_pkg;
   typedef enum logic [3:0] {
      HSQ_IDLE,
      HSQ_SEEK,
      HSQ_ON_SW,
      HSQ_REV_WAIT_ON,
      HSQ_REV_WAIT_OFF,
      HSQ_FINAL_OFF,
      HSQ_FINAL_ON,
      HSQ_WAIT_INDEX,
      HSQ_LIM_RELEASE,
      HSQ_STOPPING,
      HSQ_DONE,
      HSQ_FAULT
   } hsq_state_e;
   typedef logic [7:0] hsq_method_t;
endpackage

// [core/hsq_homing_seq.sv]
// homing sequencer for methods 10 to 14 and 17
`timescale 1ns/10ps
`include "hsq_consts.svh"

module hsq_homing_seq
(
   // clock and reset
   input  wire logic            ref_clk,
   input  wire logic            rst_b,
   // control
   input  wire logic            homing_start,
   input  wire hsq_pkg::hsq_method_t homing_method,
   input  wire logic            motor_stopped,
   // field inputs
   input  wire logic            home_switch,
   input  wire logic            forward_limit_switch,
   input  wire logic            reverse_limit_switch,
   input  wire logic            index_pulse,
   // motion commands and status
   output logic                 move_active,
   output logic                 move_dir_pos,
   output logic                 speed_second,
   output logic                 decel_cmd,
   output logic                 home_attained,
   output logic                 target_reached,
   output logic                 method_invalid
);
   import hsq_pkg::*;

   // ----------------------------------------
   // reset release and input synchronisers
   // ----------------------------------------
   logic [1:0] rst_sync_reg;
   logic       rst_n;
   always_ff @(posedge ref_clk or negedge rst_b)
      if (!rst_b)
         rst_sync_reg <= 2'b00;
      else
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
   assign rst_n = rst_sync_reg[1];

   // field pins are asynchronous to the clock
   logic [3:0] pin_s1_reg;
   logic [3:0] pin_s2_reg;
   logic [3:0] pin_prev_reg;
   always_ff @(posedge ref_clk or negedge rst_n)
      if (!rst_n)
      begin
         pin_s1_reg   <= 4'h0;
         pin_s2_reg   <= 4'h0;
         pin_prev_reg <= 4'h0;
      end
      else
      begin
         pin_s1_reg   <= {index_pulse, reverse_limit_switch, forward_limit_switch, home_switch};
         pin_s2_reg   <= pin_s1_reg;
         pin_prev_reg <= pin_s2_reg;
      end

   wire hs      = pin_s2_reg[0];
   wire fwd_lim = pin_s2_reg[1];
   wire rev_lim = pin_s2_reg[2];
   wire hs_rise = pin_s2_reg[0] & ~pin_prev_reg[0];
   wire rev_lim_fall = ~pin_s2_reg[2] & pin_prev_reg[2];
   wire idx_rise = pin_s2_reg[3] & ~pin_prev_reg[3];

   wire m10 = (homing_method == `HSQ_METHOD_10);
   wire m11 = (homing_method == `HSQ_METHOD_11);
   wire m12 = (homing_method == `HSQ_METHOD_12);
   wire m13 = (homing_method == `HSQ_METHOD_13);
   wire m14 = (homing_method == `HSQ_METHOD_14);
   wire m17 = (homing_method == `HSQ_METHOD_17);
   // reserved codes and anything outside this block's range get no sequence
   wire method_ok = m10 | m11 | m12 | m13 | m14 | m17;

   // ----------------------------------------
   // sequence state
   // ----------------------------------------
   hsq_state_e  state_reg, state_next;
   hsq_method_t method_reg, method_next;
   logic        dir_reg, dir_next;
   logic        spd_reg, spd_next;
   logic        home_reg, home_next;
   logic        tgt_reg, tgt_next;
   logic        inval_reg, inval_next;

   wire l10 = (method_reg == `HSQ_METHOD_10);
   wire l11 = (method_reg == `HSQ_METHOD_11);
   wire l12 = (method_reg == `HSQ_METHOD_12);
   wire l13 = (method_reg == `HSQ_METHOD_13);
   wire l14 = (method_reg == `HSQ_METHOD_14);

   always_comb
   begin
      state_next  = state_reg;
      method_next = method_reg;
      dir_next    = dir_reg;
      spd_next    = spd_reg;
      home_next   = home_reg;
      tgt_next    = tgt_reg;
      inval_next  = inval_reg;
      case (state_reg)
         HSQ_IDLE, HSQ_DONE, HSQ_FAULT:
         begin
            if (homing_start)
            begin
               method_next = homing_method;
               home_next   = 1'b0;
               tgt_next    = 1'b0;
               inval_next  = 1'b0;
               if (!method_ok)
               begin
                  inval_next = 1'b1;
                  state_next = HSQ_FAULT;
               end
               else if (m17)
               begin
                  dir_next   = `HSQ_DIR_NEG;
                  spd_next   = `HSQ_SPEED_FIRST;
                  state_next = HSQ_SEEK;
               end
               else if (hs && (m10 || m11 || m14))
               begin
                  dir_next   = m14 ? `HSQ_DIR_NEG : `HSQ_DIR_POS;
                  spd_next   = `HSQ_SPEED_SECOND;
                  state_next = HSQ_FINAL_OFF;
               end
               // m12/m13 start on switch, leave it first
               else if (hs && (m12 || m13))
               begin
                  dir_next   = m12 ? `HSQ_DIR_POS : `HSQ_DIR_NEG;
                  spd_next   = `HSQ_SPEED_FIRST;
                  state_next = HSQ_REV_WAIT_OFF;
               end
               else
               begin
                  dir_next   = m10 ? `HSQ_DIR_POS : `HSQ_DIR_NEG;
                  spd_next   = m12 ? `HSQ_SPEED_SECOND : `HSQ_SPEED_FIRST;
                  state_next = HSQ_SEEK;
               end
            end
         end
         HSQ_SEEK:
         begin
            if (method_reg == `HSQ_METHOD_17)
            begin
               if (rev_lim)
               begin
                  dir_next   = `HSQ_DIR_POS;
                  spd_next   = `HSQ_SPEED_SECOND;
                  state_next = HSQ_LIM_RELEASE;
               end
            end
            else if (l10 && fwd_lim)
            begin
               dir_next   = `HSQ_DIR_NEG;
               state_next = HSQ_REV_WAIT_ON;
            end
            else if (!l10 && rev_lim)
            begin
               dir_next   = `HSQ_DIR_POS;
               spd_next   = l13 ? `HSQ_SPEED_SECOND : `HSQ_SPEED_FIRST;
               state_next = l13 ? HSQ_FINAL_ON : HSQ_REV_WAIT_ON;
            end
            else if (hs)
            begin
               if (l10 || l11 || l14)
               begin
                  dir_next   = l11 ? `HSQ_DIR_POS : dir_reg;
                  spd_next   = `HSQ_SPEED_SECOND;
                  state_next = HSQ_FINAL_OFF;
               end
               else if (l12)
                  state_next = HSQ_WAIT_INDEX;
               else
                  state_next = HSQ_REV_WAIT_OFF;
            end
         end
         HSQ_REV_WAIT_ON:
         begin
            if (hs_rise && (l10 || l11 || l14))
            begin
               dir_next   = l14 ? `HSQ_DIR_NEG : `HSQ_DIR_POS;
               spd_next   = `HSQ_SPEED_SECOND;
               state_next = HSQ_FINAL_OFF;
            end
            else if (hs_rise)
               state_next = HSQ_REV_WAIT_OFF;
         end
         HSQ_REV_WAIT_OFF:
         begin
            if (!hs)
            begin
               dir_next   = l12 ? `HSQ_DIR_NEG : `HSQ_DIR_POS;
               spd_next   = `HSQ_SPEED_SECOND;
               state_next = HSQ_FINAL_ON;
            end
         end
         HSQ_FINAL_OFF:
            if (!hs)
               state_next = HSQ_WAIT_INDEX;
         HSQ_FINAL_ON:
            if (hs)
               state_next = HSQ_WAIT_INDEX;
         HSQ_WAIT_INDEX:
         begin
            if (idx_rise)
            begin
               home_next  = 1'b1;
               state_next = HSQ_STOPPING;
            end
         end
         HSQ_LIM_RELEASE:
         begin
            if (rev_lim_fall)
            begin
               home_next  = 1'b1;
               state_next = HSQ_STOPPING;
            end
         end
         HSQ_STOPPING:
         begin
            if (motor_stopped)
            begin
               tgt_next   = 1'b1;
               state_next = HSQ_DONE;
            end
         end
         default:
            state_next = HSQ_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n)
      if (!rst_n)
      begin
         state_reg  <= HSQ_IDLE;
         method_reg <= `HSQ_METHOD_10;
         dir_reg    <= `HSQ_DIR_POS;
         spd_reg    <= `HSQ_SPEED_FIRST;
         home_reg   <= 1'b0;
         tgt_reg    <= 1'b0;
         inval_reg  <= 1'b0;
      end
      else
      begin
         state_reg  <= state_next;
         method_reg <= method_next;
         dir_reg    <= dir_next;
         spd_reg    <= spd_next;
         home_reg   <= home_next;
         tgt_reg    <= tgt_next;
         inval_reg  <= inval_next;
      end

   // ----------------------------------------
   // registered outputs
   // ----------------------------------------
   wire moving = (state_reg != HSQ_IDLE) && (state_reg != HSQ_DONE)
               && (state_reg != HSQ_FAULT) && (state_reg != HSQ_STOPPING);
   always_ff @(posedge ref_clk or negedge rst_n)
      if (!rst_n)
      begin
         move_active    <= 1'b0;
         move_dir_pos   <= `HSQ_DIR_POS;
         speed_second   <= `HSQ_SPEED_FIRST;
         decel_cmd      <= 1'b0;
         home_attained  <= 1'b0;
         target_reached <= 1'b0;
         method_invalid <= 1'b0;
      end
      else
      begin
         move_active    <= moving;
         move_dir_pos   <= dir_reg;
         speed_second   <= spd_reg;
         decel_cmd      <= (state_reg == HSQ_STOPPING);
         home_attained  <= home_reg;
         target_reached <= tgt_reg;
         method_invalid <= inval_reg;
      end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   property p_home_decel;
      @(posedge ref_clk) disable iff (!rst_n)
      (state_reg == HSQ_WAIT_INDEX && idx_rise) |-> ##2 (home_attained && decel_cmd);
   endproperty
   a_home_decel: assert property (p_home_decel) else $error("home not flagged");
   property p_tgt_stop;
      @(posedge ref_clk) disable iff (!rst_n)
      $rose(tgt_reg) |-> $past(motor_stopped);
   endproperty
   a_tgt_stop: assert property (p_tgt_stop) else $error("target before stop");
   property p_reserved;
      @(posedge ref_clk) disable iff (!rst_n)
      (state_reg inside {HSQ_IDLE, HSQ_DONE, HSQ_FAULT} && homing_start && !method_ok)
         |-> ##1 state_reg == HSQ_FAULT;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved method ran");
   property p_m10_start;
      @(posedge ref_clk) disable iff (!rst_n)
      (state_reg inside {HSQ_IDLE, HSQ_DONE, HSQ_FAULT} && homing_start && m10 && !hs)
         |-> ##1 (dir_reg == `HSQ_DIR_POS && spd_reg == `HSQ_SPEED_FIRST);
   endproperty
   a_m10_start: assert property (p_m10_start) else $error("m10 start wrong");
   property p_m12_start;
      @(posedge ref_clk) disable iff (!rst_n)
      (state_reg inside {HSQ_IDLE, HSQ_DONE, HSQ_FAULT} && homing_start && m12 && !hs)
         |-> ##1 (dir_reg == `HSQ_DIR_NEG && spd_reg == `HSQ_SPEED_SECOND);
   endproperty
   a_m12_start: assert property (p_m12_start) else $error("m12 start wrong");
   property p_index_gate;
      @(posedge ref_clk) disable iff (!rst_n)
      $rose(home_reg) |-> $past(state_reg) inside {HSQ_WAIT_INDEX, HSQ_LIM_RELEASE};
   endproperty
   a_index_gate: assert property (p_index_gate) else $error("early home");
   property p_m17_release;
      @(posedge ref_clk) disable iff (!rst_n)
      (state_reg == HSQ_LIM_RELEASE) |-> (dir_reg == `HSQ_DIR_POS && spd_reg);
   endproperty
   a_m17_release: assert property (p_m17_release) else $error("m17 backoff wrong");
   property p_m10_fwd_lim;
      @(posedge ref_clk) disable iff (!rst_n)
      (state_reg == HSQ_SEEK && l10 && fwd_lim) |-> ##1 (dir_reg == `HSQ_DIR_NEG);
   endproperty
   a_m10_fwd_lim: assert property (p_m10_fwd_lim) else $error("m10 no reverse");

endmodule // hsq_homing_seq

// [bench/hsq_axis_model.sv]
// axis model giving home switch, limit switches, index pulse and stop sense
`timescale 1ns/10ps
module hsq_axis_model
(
   // clock
   input  wire logic               ref_clk,
   // bench control
   input  wire logic               load,
   input  wire logic signed [15:0] load_pos,
   // motion commands from the sequencer
   input  wire logic               move_active,
   input  wire logic               move_dir_pos,
   input  wire logic               speed_second,
   input  wire logic               decel_cmd,
   // position for the bench, sensors seen by the sequencer
   output logic signed [15:0]      axis_pos,
   output logic                    home_switch,
   output logic                    forward_limit_switch,
   output logic                    reverse_limit_switch,
   output logic                    index_pulse,
   output logic                    motor_stopped
);
   localparam logic signed [15:0] HS_LO = 16'sh005a;
   localparam logic signed [15:0] HS_HI = 16'sh006d;
   localparam logic signed [15:0] FL_AT = 16'sh00c8;
   logic [3:0] step_cnt;
   logic [3:0] dec_cnt;
   logic       step_now;
   // second speed is four times slower so the index stays up past the latency
   assign step_now = step_cnt >= (speed_second ? 4'hf : 4'h3);
   assign home_switch = (axis_pos >= HS_LO) && (axis_pos <= HS_HI);
   assign forward_limit_switch = axis_pos >= FL_AT;
   assign reverse_limit_switch = axis_pos <= 16'sh0000;
   assign index_pulse = (axis_pos % 16'sh000a) == 16'sh0005;
   initial
   begin
      axis_pos = 16'sh0000;
      step_cnt = 4'h0;
      dec_cnt = 4'h0;
      motor_stopped = 1'b1;
   end
   // sensors move on the falling edge, like every bench driver
   always @(negedge ref_clk)
   begin
      if (load)
      begin
         axis_pos <= load_pos;
         step_cnt <= 4'h0;
      end
      else if (move_active && !decel_cmd)
      begin
         step_cnt <= step_now ? 4'h0 : step_cnt + 4'h1;
         if (step_now)
            axis_pos <= move_dir_pos ? axis_pos + 16'sh0001 : axis_pos - 16'sh0001;
      end
      // ramp down takes eight cycles before the motor reports rest
      if (decel_cmd ? (dec_cnt >= 4'h7) : !move_active)
         motor_stopped <= 1'b1;
      else
         motor_stopped <= 1'b0;
      dec_cnt <= (decel_cmd && dec_cnt < 4'h8) ? dec_cnt + 4'h1 : (decel_cmd ? dec_cnt : 4'h0);
   end
endmodule // hsq_axis_model

// [bench/hsq_homing_seq_test.sv]
// self-checking bench for the homing sequencer
`timescale 1ns/10ps
module hsq_homing_seq_test;
   logic               ref_clk;
   logic               rst_b;
   logic               homing_start;
   logic [7:0]         homing_method;
   logic               motor_stopped;
   logic               home_switch;
   logic               forward_limit_switch;
   logic               reverse_limit_switch;
   logic               index_pulse;
   logic               move_active;
   logic               move_dir_pos;
   logic               speed_second;
   logic               decel_cmd;
   logic               home_attained;
   logic               target_reached;
   logic               method_invalid;
   logic               load;
   logic signed [15:0] load_pos;
   logic signed [15:0] axis_pos;
   int                 n_mismatch = 0;
   int                 checks = 0;
   int                 cycles = 0;

   hsq_homing_seq hsq_homing_seq_i (.ref_clk(ref_clk), .rst_b(rst_b),
      .homing_start(homing_start), .homing_method(homing_method),
      .motor_stopped(motor_stopped), .home_switch(home_switch),
      .forward_limit_switch(forward_limit_switch), .reverse_limit_switch(reverse_limit_switch),
      .index_pulse(index_pulse), .move_active(move_active), .move_dir_pos(move_dir_pos),
      .speed_second(speed_second), .decel_cmd(decel_cmd), .home_attained(home_attained),
      .target_reached(target_reached), .method_invalid(method_invalid));

   hsq_axis_model hsq_axis_model_i (.ref_clk(ref_clk), .load(load), .load_pos(load_pos),
      .move_active(move_active), .move_dir_pos(move_dir_pos), .speed_second(speed_second),
      .decel_cmd(decel_cmd), .axis_pos(axis_pos), .home_switch(home_switch),
      .forward_limit_switch(forward_limit_switch), .reverse_limit_switch(reverse_limit_switch),
      .index_pulse(index_pulse), .motor_stopped(motor_stopped));

   // ---------------------------------------------
   // common tasks
   // ---------------------------------------------
   task automatic stop_test();
      $display("mismatches %0d, checks %0d", n_mismatch, checks);
      if (n_mismatch == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic start(input logic [7:0] meth, input logic signed [15:0] p0);
      @(negedge ref_clk);
      load = 1'b1;
      load_pos = p0;
      @(negedge ref_clk);
      load = 1'b0;
      // let the switch synchronisers see the new position before starting
      repeat (4) @(negedge ref_clk);
      homing_start = 1'b1;
      homing_method = meth;
      @(negedge ref_clk);
      homing_start = 1'b0;
      repeat (4) @(negedge ref_clk);
   endtask

   // start, check the first move, wait for home, check home and stop
   task automatic run(input logic [7:0] meth, input logic signed [15:0] p0, input logic d0,
                      input logic s0, input logic sck, input logic signed [15:0] ph,
                      input logic dh);
      int n;
      start(meth, p0);
      cmp(move_active, 1'b1);
      cmp(move_dir_pos, d0);
      if (sck)
         cmp(speed_second, s0);
      cmp(home_attained, 1'b0);
      n = 0;
      while (home_attained !== 1'b1 && n < 3000)
      begin
         @(negedge ref_clk);
         n++;
      end
      cmp(axis_pos, ph);
      cmp(move_dir_pos, dh);
      cmp(speed_second, 1'b1);
      cmp(decel_cmd, 1'b1);
      cmp(target_reached, 1'b0);
      // the axis is still ramping down here
      repeat (4) @(negedge ref_clk);
      cmp(motor_stopped, 1'b0);
      cmp(target_reached, 1'b0);
      n = 0;
      while (target_reached !== 1'b1 && n < 40)
      begin
         @(negedge ref_clk);
         n++;
      end
      cmp(target_reached, 1'b1);
      cmp(motor_stopped, 1'b1);
   endtask

   // ---------------------------------------------
   // scenarios
   // ---------------------------------------------
   task automatic t_m10();
      run(8'h0a, 16'sh0032, 1'b1, 1'b0, 1'b1, 16'sh0073, 1'b1);
      run(8'h0a, 16'sh0096, 1'b1, 1'b0, 1'b1, 16'sh0073, 1'b1);
      run(8'h0a, 16'sh0064, 1'b1, 1'b1, 1'b1, 16'sh0073, 1'b1);
   endtask

   task automatic t_m11();
      run(8'h0b, 16'sh0096, 1'b0, 1'b0, 1'b1, 16'sh0073, 1'b1);
      run(8'h0b, 16'sh0032, 1'b0, 1'b0, 1'b1, 16'sh0073, 1'b1);
      run(8'h0b, 16'sh0064, 1'b1, 1'b1, 1'b1, 16'sh0073, 1'b1);
   endtask

   task automatic t_m12();
      run(8'h0c, 16'sh0096, 1'b0, 1'b1, 1'b1, 16'sh0069, 1'b0);
      run(8'h0c, 16'sh0032, 1'b0, 1'b1, 1'b1, 16'sh0069, 1'b0);
      run(8'h0c, 16'sh0064, 1'b1, 1'b0, 1'b1, 16'sh0069, 1'b0);
   endtask

   task automatic t_m13();
      run(8'h0d, 16'sh0096, 1'b0, 1'b0, 1'b1, 16'sh005f, 1'b1);
      run(8'h0d, 16'sh0032, 1'b0, 1'b0, 1'b1, 16'sh005f, 1'b1);
      run(8'h0d, 16'sh0064, 1'b0, 1'b0, 1'b0, 16'sh005f, 1'b1);
   endtask

   task automatic t_m14_m17();
      run(8'h0e, 16'sh0096, 1'b0, 1'b0, 1'b1, 16'sh0055, 1'b0);
      run(8'h0e, 16'sh0032, 1'b0, 1'b0, 1'b1, 16'sh0055, 1'b0);
      run(8'h0e, 16'sh0064, 1'b0, 1'b1, 1'b1, 16'sh0055, 1'b0);
      run(8'h11, 16'sh0032, 1'b0, 1'b0, 1'b1, 16'sh0001, 1'b1);
   endtask

   // reserved and unknown codes must not move the axis
   task automatic t_reserved();
      logic [7:0] codes [3] = '{8'h0f, 8'h10, 8'h09};
      foreach (codes[i])
      begin
         start(codes[i], 16'sh0032);
         cmp(method_invalid, 1'b1);
         cmp(move_active, 1'b0);
         cmp(axis_pos, 16'sh0032);
      end
   endtask

   // ---------------------------------------------
   // clock, timeout and main sequence
   // ---------------------------------------------
   initial
   begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   // longest method takes about 1750 cycles, sixteen runs fit well inside
   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 60000)
      begin
         n_mismatch++;
         stop_test();
      end
   end

   initial
   begin
      rst_b = 1'b0;
      homing_start = 1'b0;
      homing_method = 8'h00;
      load = 1'b0;
      load_pos = 16'sh0000;
      repeat (2) @(posedge ref_clk);
      @(negedge ref_clk);
      cmp({move_active, move_dir_pos, speed_second, decel_cmd, home_attained,
           target_reached, method_invalid}, 16'h0020);
      rst_b = 1'b1;
      repeat (4) @(negedge ref_clk);
      t_reserved();
      t_m10();
      t_m11();
      t_m12();
      t_m13();
      t_m14_m17();
      stop_test();
   end
endmodule // hsq_homing_seq_test
